// ==== tas_host_model.sv ====
// SMBus host model: bit-level master for the temperature alarm slave.
// Assumes a pull-up on SDA and that tasks are entered just after a clock edge.
module tas_host_model (
  input wire logic clock,
  input wire logic dev_sda_oe,
  input wire logic rival_low,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_low;
  // A rival slave may also pull SDA during alert-response arbitration
  assign sda = ~(sda_low | dev_sda_oe | rival_low);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Half of an SCL period, above the six-clock minimum
  task automatic half();
    repeat (8) @(posedge clock);
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    @(posedge clock);
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clock);
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
  // MSB first; ninth bit released, so a read byte ends unacknowledged
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nack);
    logic [8:0] w;
    logic [8:0] r;
    w = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      @(posedge clock);
      sda_low <= ~w[i];
      half();
      scl <= 1'b1;
      half();
      r[i] = sda;
      scl <= 1'b0;
    end
    q = r[8:1];
    nack = r[0];
  endtask
endmodule

// ==== tas_pkg.sv ====
// Constants shared by the temperature alarm SMBus slave.
// Assumes a 10 MHz system clock and an SMBus host on the far side.
package tas_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TIMEOUT_MS = 35;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int TMO_W = 20;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  // Command codes
  localparam logic [7:0] CMD_RD_TLO = 8'h00;
  localparam logic [7:0] CMD_RD_THI = 8'h01;
  localparam logic [7:0] CMD_RD_STAT = 8'h02;
  localparam logic [7:0] CMD_RD_CFG = 8'h03;
  localparam logic [7:0] CMD_RD_UPPER = 8'h07;
  localparam logic [7:0] CMD_RD_LOWER = 8'h08;
  localparam logic [7:0] CMD_WR_CFG = 8'h09;
  localparam logic [7:0] CMD_WR_UPPER = 8'h0D;
  localparam logic [7:0] CMD_WR_LOWER = 8'h0E;
  localparam logic [7:0] CMD_ONESHOT = 8'h0F;
  localparam logic [7:0] CMD_RD_TRIP = 8'h10;
  localparam logic [7:0] CMD_RD_REL = 8'h11;
  localparam logic [7:0] CMD_WR_TRIP = 8'h12;
  localparam logic [7:0] CMD_WR_REL = 8'h13;
  localparam logic [7:0] CMD_PTR_RST = 8'h00;
  // Reset values of the limits
  localparam logic [7:0] UPPER_RST = 8'h7F;
  localparam logic [7:0] LOWER_RST = 8'hC9;
  localparam logic [7:0] TRIP_RST = 8'h64;
  localparam logic [7:0] REL_RST = 8'h5F;
  localparam logic [7:0] CFG_RST = 8'h00;
  // Configuration bits
  localparam int CFG_ARA_ONLY = 0;
  localparam int CFG_OVT_MASK = 1;
  localparam int CFG_EXT_IGN = 2;
  localparam int CFG_OVT_POL = 5;
  localparam int CFG_ALERT_MASK = 7;
  // Status bits
  localparam int ST_OVT = 1;
  localparam int ST_OPEN = 2;
  localparam int ST_LOWER = 3;
  localparam int ST_UPPER = 4;
  localparam int ST_ALERT = 6;
  localparam int COH_BIT = 4;
  localparam int FRAC_W = 3;
  localparam int STRAP_WAIT = 2;
  typedef enum logic [2:0] {
    TAS_IDLE, TAS_ADDR, TAS_ACK, TAS_CMD, TAS_DATA, TAS_TX, TAS_MACK, TAS_WAIT
  } tas_state_type;
endpackage

// ==== tas_smbus_slave.sv ====
// SMBus slave with remote temperature result, alarm limits, alert and over-temperature.
// Assumes conversions arrive on adc_clk; SMBus pins and straps are asynchronous to clock.

// Overview of operation
// - Write byte: address+W, ack, command, ack, data, ack, stop.
// - Read byte: address+W, command, repeated start, address+R, one data byte, nack.
// - Send byte carries address+W and only a command byte.
// - Receive byte returns register of last command; also serves alert response.
// - Interface resets when either bus line stays low over 35 ms.
// - Result is 11-bit two's complement, 0.125 C per bit.
// - High byte holds sign and next seven bits; low byte bits 7..5 hold rest.
// - Low byte bit 4 is 1 when high and low come from different conversions.
// - Four limit registers are two's complement, 1 C per bit.
// - Alert when temperature at or above upper limit or below lower limit.
// - Over-temperature at or above trip; over-temp (not alert) releases below release limit.
// - Reset limits: upper +127, lower -55, trip +100, release +95.
// - Config bit 1 masks over-temp output; active low, bit 5 inverts polarity.
// - External over-temp activation is ignored when config bit 2 set.
// - Active over-temp line forces fan full speed and sets status bit 1.
// - Diode fault zeroes high byte; open also sets status bit 2 and alerts.
// - Limit hits, diode fault, over-temp raise alert and status; config bit 7 masks.
// - Alert open-drain low; cleared by status read or ARA; re-evaluated per conversion.
// - With config bit 0 set, status clears only via alert response.
// - Upper or lower limit alert only once, even after a later re-crossing; re-armed by rewriting that limit register.
// - Alert response returns own address; lower address wins; loser keeps alert.
// - Alert response byte is address in bits 7..1 and 1 in bit 0.
// - Command pointer resets to zero so receive byte returns temperature.
module tas_smbus_slave
  import tas_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic adc_clk,
  input wire logic adc_done,
  input wire logic [10:0] adc_temp,
  input wire logic adc_open,
  input wire logic adc_short,
  input wire logic [6:0] addr_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic alert_n_out,
  output logic alert_oe,
  input wire logic overtemp_line_in,
  output logic overtemp_shutdown_out,
  output logic fan_full_speed,
  output logic oneshot_req
);
  // Conversion domain: hold the result and flag it with a toggle
  logic adc_tgl_ff;
  logic [10:0] adc_temp_ff;
  logic adc_open_ff, adc_short_ff;
  always_ff @(posedge adc_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_tgl_ff <= 1'b0;
      adc_temp_ff <= 11'h000;
      adc_open_ff <= 1'b0;
      adc_short_ff <= 1'b0;
    end else if (adc_done) begin
      adc_tgl_ff <= ~adc_tgl_ff;
      adc_temp_ff <= adc_temp;
      adc_open_ff <= adc_open;
      adc_short_ff <= adc_short;
    end
  end

  // Synchronisers for pins and the conversion toggle
  logic scl_meta_ff, scl_s_ff, scl_d_ff, sda_meta_ff, sda_s_ff, sda_d_ff;
  logic ovl_meta_ff, ovl_s_ff, tgl_meta_ff, tgl_s_ff, tgl_d_ff;
  logic [6:0] strap_meta_ff, strap_s_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_meta_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      ovl_meta_ff <= 1'b1;
      ovl_s_ff <= 1'b1;
      tgl_meta_ff <= 1'b0;
      tgl_s_ff <= 1'b0;
      tgl_d_ff <= 1'b0;
      strap_meta_ff <= 7'h00;
      strap_s_ff <= 7'h00;
    end else begin
      scl_meta_ff <= scl_in;
      scl_s_ff <= scl_meta_ff;
      scl_d_ff <= scl_s_ff;
      sda_meta_ff <= sda_in;
      sda_s_ff <= sda_meta_ff;
      sda_d_ff <= sda_s_ff;
      ovl_meta_ff <= overtemp_line_in;
      ovl_s_ff <= ovl_meta_ff;
      tgl_meta_ff <= adc_tgl_ff;
      tgl_s_ff <= tgl_meta_ff;
      tgl_d_ff <= tgl_s_ff;
      strap_meta_ff <= addr_strap;
      strap_s_ff <= strap_meta_ff;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, conv_end;
  assign scl_rise = scl_s_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s_ff & scl_d_ff;
  assign bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  assign bus_stop = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
  assign conv_end = tgl_s_ff ^ tgl_d_ff;

  // Slave address strap is sampled on the first three cycles after reset release, then held
  logic [1:0] strap_cnt_ff;
  logic [6:0] own_addr_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_ff <= 2'h0;
      own_addr_ff <= 7'h00;
    end else if (strap_cnt_ff <= 2'(STRAP_WAIT)) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      own_addr_ff <= strap_s_ff;
    end
  end

  // Bus timeout
  logic [TMO_W-1:0] tmo_cnt_ff;
  logic tmo_hit;
  assign tmo_hit = (tmo_cnt_ff == TMO_W'(TIMEOUT_CYCLES - 1));
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tmo_cnt_ff <= '0;
    end else if (scl_s_ff & sda_s_ff) begin
      tmo_cnt_ff <= '0;
    end else if (!tmo_hit) begin
      tmo_cnt_ff <= tmo_cnt_ff + TMO_W'(1);
    end
  end

  // Protocol engine
  tas_state_type state_ff, ack_ret_ff;
  logic [7:0] rx_sh_ff, tx_sh_ff, cmd_ptr_ff, rdata;
  logic [2:0] bit_cnt_ff;
  logic rw_ff, ara_ff, ack_on_ff, drv_ff, alert_latch_ff;
  logic [7:0] rx_byte;
  logic addr_own, addr_ara, cmd_take, wr_en, rd_load, tx_lost, tx_done;
  assign rx_byte = {rx_sh_ff[6:0], sda_s_ff};
  assign addr_own = (rx_byte[7:1] == own_addr_ff);
  assign addr_ara = (rx_byte[7:1] == ARA_ADDR) & rx_byte[0] & alert_latch_ff;
  assign cmd_take = (state_ff == TAS_CMD) & scl_rise & (bit_cnt_ff == 3'h7);
  assign wr_en = (state_ff == TAS_DATA) & scl_rise & (bit_cnt_ff == 3'h7);
  assign rd_load = (state_ff == TAS_ACK) & scl_fall & ack_on_ff & rw_ff;
  assign tx_lost = (state_ff == TAS_TX) & scl_rise & tx_sh_ff[7] & ~sda_s_ff;
  assign tx_done = (state_ff == TAS_TX) & scl_rise & ~tx_lost & (bit_cnt_ff == 3'h7);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= TAS_IDLE;
      ack_ret_ff <= TAS_IDLE;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      rw_ff <= 1'b0;
      ara_ff <= 1'b0;
      ack_on_ff <= 1'b0;
      drv_ff <= 1'b0;
    end else if (tmo_hit || bus_stop) begin
      state_ff <= TAS_IDLE;
      drv_ff <= 1'b0;
      ack_on_ff <= 1'b0;
    end else if (bus_start) begin
      state_ff <= TAS_ADDR;
      bit_cnt_ff <= 3'h0;
      drv_ff <= 1'b0;
      ack_on_ff <= 1'b0;
    end else begin
      case (state_ff)
        TAS_ADDR, TAS_CMD, TAS_DATA: begin
          if (scl_rise) begin
            rx_sh_ff <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              state_ff <= TAS_ACK;
              if (state_ff == TAS_ADDR) begin
                rw_ff <= rx_byte[0];
                ara_ff <= ~addr_own;
                ack_ret_ff <= TAS_CMD;
                if (!addr_own && !addr_ara) begin
                  state_ff <= TAS_WAIT;
                end
              end else if (state_ff == TAS_CMD) begin
                ack_ret_ff <= TAS_DATA;
              end else begin
                ack_ret_ff <= TAS_WAIT;
              end
            end
          end
        end
        TAS_ACK: begin
          if (scl_fall) begin
            if (!ack_on_ff) begin
              drv_ff <= 1'b1;
              ack_on_ff <= 1'b1;
            end else begin
              ack_on_ff <= 1'b0;
              bit_cnt_ff <= 3'h0;
              if (rw_ff) begin
                tx_sh_ff <= ara_ff ? {own_addr_ff, 1'b1} : rdata;
                drv_ff <= ara_ff ? (own_addr_ff[6] == 1'b0) : ~rdata[7];
                state_ff <= TAS_TX;
              end else begin
                drv_ff <= 1'b0;
                state_ff <= ack_ret_ff;
              end
            end
          end
        end
        TAS_TX: begin
          if (tx_lost) begin
            drv_ff <= 1'b0;
            state_ff <= TAS_WAIT;
          end else if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              state_ff <= TAS_MACK;
            end
          end else if (scl_fall) begin
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            drv_ff <= ~tx_sh_ff[6];
          end
        end
        TAS_MACK: begin
          if (scl_fall) begin
            drv_ff <= 1'b0;
            state_ff <= TAS_WAIT;
          end
        end
        default: begin
          drv_ff <= 1'b0;
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drv_ff;

  // Command pointer and one-shot request
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ptr_ff <= CMD_PTR_RST;
      oneshot_req <= 1'b0;
    end else begin
      oneshot_req <= cmd_take & (rx_byte == CMD_ONESHOT);
      if (cmd_take) begin
        cmd_ptr_ff <= rx_byte;
      end
    end
  end

  // Configuration and limit registers
  logic [7:0] cfg_ff, upper_ff, lower_ff, trip_ff, rel_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= CFG_RST;
      upper_ff <= UPPER_RST;
      lower_ff <= LOWER_RST;
      trip_ff <= TRIP_RST;
      rel_ff <= REL_RST;
    end else if (wr_en) begin
      if (cmd_ptr_ff == CMD_WR_CFG) begin
        cfg_ff <= rx_byte;
      end else if (cmd_ptr_ff == CMD_WR_UPPER) begin
        upper_ff <= rx_byte;
      end else if (cmd_ptr_ff == CMD_WR_LOWER) begin
        lower_ff <= rx_byte;
      end else if (cmd_ptr_ff == CMD_WR_TRIP) begin
        trip_ff <= rx_byte;
      end else if (cmd_ptr_ff == CMD_WR_REL) begin
        rel_ff <= rx_byte;
      end
    end
  end

  // Result registers and coherence flag
  logic [7:0] temp_hi_ff;
  logic [FRAC_W-1:0] temp_lo_ff;
  logic coh_ff, fault_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      temp_hi_ff <= 8'h00;
      temp_lo_ff <= '0;
      coh_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      if (conv_end) begin
        fault_ff <= adc_open_ff | adc_short_ff;
        temp_hi_ff <= (adc_open_ff | adc_short_ff) ? 8'h00 : adc_temp_ff[10:3];
        temp_lo_ff <= adc_temp_ff[FRAC_W-1:0];
      end
      if (conv_end) begin
        coh_ff <= 1'b1;
      end else if (rd_load && !ara_ff && cmd_ptr_ff == CMD_RD_THI) begin
        coh_ff <= 1'b0;
      end
    end
  end

  // Limit checks on the newest result
  logic signed [10:0] temp_s;
  logic hit_upper, hit_lower, hit_trip, below_rel;
  assign temp_s = {temp_hi_ff, temp_lo_ff};
  assign hit_upper = ~fault_ff & (temp_s >= $signed({upper_ff, 3'h0}));
  assign hit_lower = ~fault_ff & (temp_s < $signed({lower_ff, 3'h0}));
  assign hit_trip = ~fault_ff & (temp_s >= $signed({trip_ff, 3'h0}));
  assign below_rel = temp_s < $signed({rel_ff, 3'h0});

  // Evaluation is one cycle after the result lands
  logic eval_ff, ovt_st_ff, armed_up_ff, armed_lo_ff;
  logic [7:0] status_ff;
  logic ovt_own, ovt_lvl, ovt_line_act, ev_up, ev_lo, ev_any, clr_status;
  assign ovt_own = ovt_st_ff & ~cfg_ff[CFG_OVT_MASK];
  assign ovt_lvl = cfg_ff[CFG_OVT_POL];
  assign ovt_line_act = ovt_own | ((ovl_s_ff == ovt_lvl) & ~cfg_ff[CFG_EXT_IGN]);
  assign ev_up = hit_upper & armed_up_ff;
  assign ev_lo = hit_lower & armed_lo_ff;
  assign ev_any = ev_up | ev_lo | fault_ff | ovt_line_act;
  assign clr_status = (tx_done & ~ara_ff & (cmd_ptr_ff == CMD_RD_STAT)
                      & ~cfg_ff[CFG_ARA_ONLY]) | (tx_done & ara_ff);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eval_ff <= 1'b0;
      ovt_st_ff <= 1'b0;
      armed_up_ff <= 1'b1;
      armed_lo_ff <= 1'b1;
    end else begin
      eval_ff <= conv_end;
      if (eval_ff && hit_trip) begin
        ovt_st_ff <= 1'b1;
      end else if (eval_ff && below_rel) begin
        ovt_st_ff <= 1'b0;
      end
      if (wr_en && cmd_ptr_ff == CMD_WR_UPPER) begin
        armed_up_ff <= 1'b1;
      end else if (eval_ff && ev_up) begin
        armed_up_ff <= 1'b0;
      end
      if (wr_en && cmd_ptr_ff == CMD_WR_LOWER) begin
        armed_lo_ff <= 1'b1;
      end else if (eval_ff && ev_lo) begin
        armed_lo_ff <= 1'b0;
      end
    end
  end

  // Sticky status and alert latch; a new event beats a clear in the same cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= 8'h00;
      alert_latch_ff <= 1'b0;
    end else begin
      if (eval_ff && ev_any && !cfg_ff[CFG_ALERT_MASK]) begin
        alert_latch_ff <= 1'b1;
      end else if (clr_status) begin
        alert_latch_ff <= 1'b0;
      end
      for (int i = 0; i < 8; i++) begin
        if (eval_ff && ((i == ST_UPPER && ev_up) || (i == ST_LOWER && ev_lo)
            || (i == ST_OPEN && fault_ff && adc_open_ff)
            || (i == ST_ALERT && ev_any && !cfg_ff[CFG_ALERT_MASK]))) begin
          status_ff[i] <= 1'b1;
        end else if (clr_status) begin
          status_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Pin drivers for alert, over-temperature and fan
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overtemp_shutdown_out <= 1'b1;
      fan_full_speed <= 1'b0;
    end else begin
      overtemp_shutdown_out <= ovt_own ? ovt_lvl : ~ovt_lvl;
      fan_full_speed <= ovt_line_act;
    end
  end
  assign alert_n_out = 1'b0;
  assign alert_oe = alert_latch_ff & ~cfg_ff[CFG_ALERT_MASK];

  // Read data selection
  always_comb begin
    rdata = 8'h00;
    if (cmd_ptr_ff == CMD_RD_TLO) begin
      rdata = {temp_lo_ff, coh_ff, 4'h0};
    end else if (cmd_ptr_ff == CMD_RD_THI) begin
      rdata = temp_hi_ff;
    end else if (cmd_ptr_ff == CMD_RD_STAT) begin
      rdata = status_ff | (8'h01 << ST_OVT) & {8{ovt_line_act}};
    end else if (cmd_ptr_ff == CMD_RD_CFG) begin
      rdata = cfg_ff;
    end else if (cmd_ptr_ff == CMD_RD_UPPER) begin
      rdata = upper_ff;
    end else if (cmd_ptr_ff == CMD_RD_LOWER) begin
      rdata = lower_ff;
    end else if (cmd_ptr_ff == CMD_RD_TRIP) begin
      rdata = trip_ff;
    end else if (cmd_ptr_ff == CMD_RD_REL) begin
      rdata = rel_ff;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_fault_conv;
    conv_end && (adc_open_ff || adc_short_ff);
  endsequence
  sequence s_ara_win;
    tx_done && ara_ff && !(eval_ff && ev_any && !cfg_ff[CFG_ALERT_MASK]);
  endsequence

  a_timeout_release: assert property (tmo_hit |=> state_ff == TAS_IDLE && !sda_oe)
    else $error("timeout did not release bus");
  a_fault_zero_hi: assert property (s_fault_conv |=> temp_hi_ff == 8'h00 ##1 fault_ff)
    else $error("diode fault did not zero high byte");
  a_coh_new_conv: assert property (conv_end |=> coh_ff [*1] ##0 rdata[COH_BIT] || cmd_ptr_ff
    != CMD_RD_TLO)
    else $error("coherence flag not set after new conversion");
  a_alert_masked: assert property (cfg_ff[CFG_ALERT_MASK] |-> !alert_oe)
    else $error("alert driven while masked");
  a_ovt_polarity: assert property (##1 overtemp_shutdown_out == ($past(ovt_own) ?
    $past(ovt_lvl) : !$past(ovt_lvl)))
    else $error("over-temp pin polarity wrong");
  a_fan_follow: assert property (ovt_line_act |=> fan_full_speed)
    else $error("fan not forced by over-temp line");
  a_ara_clears: assert property (s_ara_win |=> !alert_latch_ff)
    else $error("alert response did not clear latch");
  a_foreign_addr: assert property (state_ff == TAS_ADDR && scl_rise && bit_cnt_ff == 3'h7
    && !addr_own && !addr_ara && !tmo_hit && !bus_stop && !bus_start
    |=> state_ff == TAS_WAIT ##1 !sda_oe)
    else $error("foreign address acknowledged");
  a_ptr_after_reset: assert property ($rose(strap_cnt_ff[0]) && strap_cnt_ff == 2'h1
    |-> cmd_ptr_ff == CMD_PTR_RST || $past(cmd_take))
    else $error("command pointer not reset");
  a_arm_once: assert property (eval_ff && ev_up && !(wr_en && cmd_ptr_ff == CMD_WR_UPPER)
    |=> !armed_up_ff)
    else $error("upper alert not disarmed");
endmodule

// ==== temp_alarm_smbus_slave_tb_top.sv ====
// Testbench for the temperature alarm SMBus slave.
// Assumes the host model drives the bus and conversions arrive on their own clock.
module temp_alarm_smbus_slave_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADR = 7'h4C;
  localparam logic [6:0] ARA = 7'h0C;
  logic clock, reset_n, adc_clk, adc_done, adc_open, ext_ot, n, rival, adc_sh;
  logic [10:0] adc_temp;
  logic [7:0] q;
  logic scl, sda, sda_oe, alert_oe, ot_out, fan, osr;
  wire logic ot_line;
  int err_total, num_checks, shots;
  // Shared over-temperature line: external source pulls it low
  assign ot_line = ext_ot ? 1'b0 : ot_out;
  tas_smbus_slave #(.TIMEOUT_CYCLES(600)) i_tas_smbus_slave (.clock(clock), .reset_n(reset_n),
    .adc_clk(adc_clk), .adc_done(adc_done), .adc_temp(adc_temp), .adc_open(adc_open),
    .adc_short(adc_sh), .addr_strap(ADR), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe),
    .alert_n_out(), .alert_oe(alert_oe), .overtemp_line_in(ot_line),
    .overtemp_shutdown_out(ot_out), .fan_full_speed(fan), .oneshot_req(osr));
  tas_host_model i_tas_host_model (.clock(clock), .dev_sda_oe(sda_oe), .rival_low(rival),
    .scl(scl), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    adc_clk = 1'b0;
    #3;
    forever #7.5 adc_clk = ~adc_clk;
  end
  always @(posedge clock) if (osr === 1'b1) shots++;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic a0, a1, a2;
    i_tas_host_model.start();
    i_tas_host_model.xfer({ADR, 1'b0}, r, a0);
    i_tas_host_model.xfer(c, r, a1);
    i_tas_host_model.xfer(d, r, a2);
    i_tas_host_model.stop();
    chk("write_ack", {5'h00, a0, a1, a2}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    logic a0, a1, a2, nk;
    i_tas_host_model.start();
    i_tas_host_model.xfer({ADR, 1'b0}, d, a0);
    i_tas_host_model.xfer(c, d, a1);
    i_tas_host_model.start();
    i_tas_host_model.xfer({ADR, 1'b1}, d, a2);
    i_tas_host_model.xfer(8'hFF, d, nk);
    i_tas_host_model.stop();
    chk("read_ack", {5'h00, a0, a1, a2}, 8'h00);
  endtask
  task automatic rcv(input logic [6:0] a, output logic [7:0] d, output logic nk);
    logic x;
    i_tas_host_model.start();
    i_tas_host_model.xfer({a, 1'b1}, d, nk);
    if (nk === 1'b0) i_tas_host_model.xfer(8'hFF, d, x);
    i_tas_host_model.stop();
  endtask
  task automatic conv(input logic [10:0] t, input logic op);
    @(posedge adc_clk);
    adc_done <= 1'b1;
    adc_temp <= t;
    adc_open <= op;
    @(posedge adc_clk);
    adc_done <= 1'b0;
    adc_open <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  task automatic t_reset();
    logic [7:0] cm [4] = '{8'h07, 8'h08, 8'h10, 8'h11};
    logic [7:0] ex [4] = '{8'h7F, 8'hC9, 8'h64, 8'h5F};
    chk("ovt_pin", {7'h00, ot_out}, 8'h01);
    rcv(ADR, q, n);
    chk("ptr_reset", q, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(cm[i], q);
      chk("limit_reset", q, ex[i]);
    end
  endtask
  task automatic t_result();
    conv(11'h0C8, 1'b0);
    rd(8'h01, q);
    chk("temp_high", q, 8'h19);
    rd(8'h00, q);
    chk("temp_low", q, 8'h00);
    conv(11'h7FF, 1'b0);
    rd(8'h00, q);
    chk("low_stale", q, 8'hF0);
    rd(8'h01, q);
    chk("neg_high", q, 8'hFF);
    rd(8'h00, q);
    chk("neg_low", q, 8'hE0);
  endtask
  task automatic t_addr();
    int s0;
    logic [7:0] r;
    logic a0, a1;
    rcv(ADR + 7'h01, q, n);
    chk("other_addr", {7'h00, n}, 8'h01);
    rcv(ARA, q, n);
    chk("ara_idle", {7'h00, n}, 8'h01);
    rd(8'h08, q);
    rcv(ADR, q, n);
    chk("short_read", q, 8'hC9);
    s0 = shots;
    wr(8'h0D, 8'h7F);
    i_tas_host_model.start();
    i_tas_host_model.xfer({ADR, 1'b0}, r, a0);
    i_tas_host_model.xfer(8'h0F, r, a1);
    i_tas_host_model.stop();
    chk("send_ack", {6'h00, a0, a1}, 8'h00);
    chk("oneshot", 8'(shots - s0), 8'h01);
  endtask
  task automatic t_alert();
    wr(8'h0D, 8'h14);
    conv(11'h0C8, 1'b0);
    chk("alert_set", {7'h00, alert_oe}, 8'h01);
    conv(11'h078, 1'b0);
    chk("alert_held", {7'h00, alert_oe}, 8'h01);
    i_tas_host_model.start();
    i_tas_host_model.xfer({ARA, 1'b1}, q, n);
    rival <= 1'b1;
    i_tas_host_model.xfer(8'hFF, q, n);
    rival <= 1'b0;
    i_tas_host_model.stop();
    chk("ara_lost", {7'h00, alert_oe}, 8'h01);
    rcv(ARA, q, n);
    chk("ara_byte", q, {ADR, 1'b1});
    chk("ara_clear", {7'h00, alert_oe}, 8'h00);
    conv(11'h0C8, 1'b0);
    chk("once", {7'h00, alert_oe}, 8'h00);
    wr(8'h0D, 8'h14);
    conv(11'h0C8, 1'b0);
    chk("rearm", {7'h00, alert_oe}, 8'h01);
    rd(8'h02, q);
    chk("status", q, 8'h50);
    chk("stat_clear", {7'h00, alert_oe}, 8'h00);
    wr(8'h09, 8'h01);
    wr(8'h0D, 8'h14);
    conv(11'h0C8, 1'b0);
    rd(8'h02, q);
    chk("ara_only", {7'h00, alert_oe}, 8'h01);
    rcv(ARA, q, n);
    chk("ara_only_clr", {7'h00, alert_oe}, 8'h00);
    wr(8'h09, 8'h80);
    wr(8'h0D, 8'h14);
    conv(11'h0C8, 1'b0);
    chk("alert_mask", {7'h00, alert_oe}, 8'h00);
    wr(8'h09, 8'h00);
    rd(8'h02, q);
    wr(8'h0D, 8'h7F);
  endtask
  task automatic t_ovt();
    logic [10:0] tv [3] = '{11'h328, 11'h308, 11'h2F0};
    logic [1:0] ev [3] = '{2'h2, 2'h2, 2'h1};
    for (int i = 0; i < 3; i++) begin
      conv(tv[i], 1'b0);
      chk("fan_pin", {6'h00, fan, ot_out}, {6'h00, ev[i]});
    end
    wr(8'h09, 8'h20);
    chk("ovt_pol", {7'h00, ot_out}, 8'h00);
    wr(8'h09, 8'h02);
    conv(11'h328, 1'b0);
    chk("ovt_mask", {7'h00, ot_out}, 8'h01);
    conv(11'h2F0, 1'b0);
    wr(8'h09, 8'h00);
    ext_ot <= 1'b1;
    repeat (8) @(posedge clock);
    chk("ext_fan", {7'h00, fan}, 8'h01);
    rd(8'h02, q);
    chk("ovt_stat", q & 8'h02, 8'h02);
    wr(8'h09, 8'h04);
    chk("ext_ignored", {7'h00, fan}, 8'h00);
    ext_ot <= 1'b0;
    wr(8'h09, 8'h00);
  endtask
  task automatic t_misc();
    logic [7:0] r;
    logic a;
    adc_sh <= 1'b1;
    conv(11'h0C8, 1'b0);
    adc_sh <= 1'b0;
    rd(8'h01, q);
    chk("short_high", q, 8'h00);
    conv(11'h0C8, 1'b1);
    rd(8'h01, q);
    chk("open_high", q, 8'h00);
    rd(8'h02, q);
    chk("open_stat", q & 8'h04, 8'h04);
    i_tas_host_model.start();
    i_tas_host_model.xfer({ADR, 1'b0}, r, a);
    repeat (800) @(posedge clock);
    i_tas_host_model.xfer(8'h0D, r, a);
    i_tas_host_model.xfer(8'h33, r, a);
    i_tas_host_model.stop();
    chk("tmo_ack", {7'h00, a}, 8'h01);
    rd(8'h07, q);
    chk("tmo_reg", q, 8'h7F);
  endtask
  initial begin
    reset_n = 1'b0;
    adc_done = 1'b0;
    adc_open = 1'b0;
    adc_temp = 11'h000;
    ext_ot = 1'b0;
    rival = 1'b0;
    adc_sh = 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (12) @(posedge clock);
    t_reset();
    t_result();
    t_addr();
    t_alert();
    t_ovt();
    t_misc();
    test_done();
  end
  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    test_done();
  end
endmodule
